// File: shared/spr_pkg.sv
// Constants for the sensor power, interrupt and output-format register bank
package spr_pkg;
    // Register addresses on the serial register bus
    localparam logic [5:0] ADDR_RATE = 6'h2c;
    localparam logic [5:0] ADDR_PWR = 6'h2d;
    localparam logic [5:0] ADDR_EN = 6'h2e;
    localparam logic [5:0] ADDR_MAP = 6'h2f;
    localparam logic [5:0] ADDR_SRC = 6'h30;
    localparam logic [5:0] ADDR_FMT = 6'h31;
    localparam logic [5:0] ADDR_DX0 = 6'h32;
    localparam logic [5:0] ADDR_DX1 = 6'h33;
    localparam logic [5:0] ADDR_DY0 = 6'h34;
    localparam logic [5:0] ADDR_DY1 = 6'h35;
    localparam logic [5:0] ADDR_DZ0 = 6'h36;
    localparam logic [5:0] ADDR_DZ1 = 6'h37;
    // Reset values and writable bits
    localparam logic [7:0] RATE_RST = 8'h0a;
    localparam logic [7:0] RATE_MASK = 8'h1f;
    localparam logic [7:0] PWR_MASK = 8'h3f;
    localparam logic [7:0] FMT_MASK = 8'hef;
    // Field positions
    localparam int RATE_LP_BIT = 4;
    localparam int PWR_LINK_BIT = 5;
    localparam int PWR_AUTO_BIT = 4;
    localparam int PWR_MEAS_BIT = 3;
    localparam int PWR_SLEEP_BIT = 2;
    localparam int FMT_ST_BIT = 7;
    localparam int FMT_SPI3_BIT = 6;
    localparam int FMT_INV_BIT = 5;
    localparam int FMT_FULL_BIT = 3;
    localparam int FMT_JUST_BIT = 2;
    // Event bit order shared by enable, routing and source registers
    localparam int EV_DR = 7;
    localparam int EV_STAP = 6;
    localparam int EV_DTAP = 5;
    localparam int EV_ACT = 4;
    localparam int EV_INACT = 3;
    localparam int EV_FF = 2;
    localparam int EV_WM = 1;
    localparam int EV_OVR = 0;
    localparam logic [7:0] SRC_CLR_MASK = 8'h7c;
    localparam logic [7:0] DATA_CLR_MASK = 8'h83;
    // Output formatting
    localparam logic [4:0] BASE_RES_W = 5'h0a;
    localparam logic [4:0] DATA_W = 5'h10;
    localparam logic [1:0] RANGE_MAX = 2'h3;
    // Serial header bits
    localparam int HDR_RW_BIT = 7;
    localparam int HDR_MB_BIT = 6;
    // Sample timing: base tick at the top output rate
    localparam int unsigned CLK_HZ = 32'h0773_5940;
    localparam int unsigned BASE_RATE_HZ = 32'h0000_0c80;
    localparam int unsigned BASE_DIV = CLK_HZ / BASE_RATE_HZ;
    localparam logic [3:0] TOP_RATE_CODE = 4'hf;
    localparam logic [15:0] SLEEP_BASE_TICKS = 16'h0190;
    // Link-mode phase of the motion functions
    typedef enum logic {
        spr_wait_inact = 1'b0,
        spr_wait_act = 1'b1
    } spr_phase_t;
endpackage : spr_pkg

// File: sim/spr_host.sv
// Host-side serial register master model, mode 3, one register per frame
module spr_host (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: clock parked high, device deselected
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // Half a serial period, 40 ns
    task automatic half();
        repeat (5) @(negedge i_clk);
    endtask : half
    // Header then one data byte; a released data line toggles so no stale bit survives
    task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {hdr, wd};
        rd = 8'h00;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            half();
            o_sclk = 1'b0;
            o_mosi = (i > 7 || !hdr[7]) ? sh[i] : ~o_mosi;
            half();
            o_sclk = 1'b1;
            if (i < 8) rd[i] = i_miso;
        end
        half();
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        half();
        half();
    endtask : xfer
endmodule : spr_host

// File: sim/test_spr_regs.sv
// Self-checking bench for the sensor power, interrupt and format registers
module test_spr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P_DIV = 4; // Short base tick keeps sleep intervals brief
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic h_sclk, h_cs_n, h_mosi, miso;
    logic o_spi_sdo, o_spi_sdo_oe, o_spi_sdio, o_spi_sdio_oe;
    logic signed [15:0] raw [3] = '{default: 16'h0000};
    logic [6:0] ev = 7'h00; // Event pulses in shared bit order
    logic o_irq_pin_a, o_irq_pin_b, o_low_power, o_self_test, o_measuring, o_asleep;
    logic [3:0] o_rate_code;
    logic o_act_run, o_inact_run, o_tap_ff_run, o_sample, o_fifo_wr;
    logic [7:0] mr [6'h2c:6'h31] = '{8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}; // Register model
    logic [7:0] fl = 8'h00; // Event flag model
    logic [7:0] rv, lo;
    int miscompares = 0;
    int n_tests = 0;
    int seed = 32'hae59_162a;
    always #4 i_core_clk = ~i_core_clk;
    // Host reads whichever pin the device drives; nothing driven reads unknown
    assign miso = o_spi_sdio_oe ? o_spi_sdio : (o_spi_sdo_oe ? o_spi_sdo : 1'bx);
    spr_host u_host (.i_clk(i_core_clk), .i_miso(miso), .o_sclk(h_sclk), .o_cs_n(h_cs_n), .o_mosi(h_mosi));
    spr_regs #(.P_BASE_DIV(P_DIV)) u_dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_spi_sclk(h_sclk),
        .i_spi_cs_n(h_cs_n), .i_spi_sdio(o_spi_sdio_oe ? o_spi_sdio : h_mosi), .o_spi_sdo(o_spi_sdo),
        .o_spi_sdo_oe(o_spi_sdo_oe), .o_spi_sdio(o_spi_sdio), .o_spi_sdio_oe(o_spi_sdio_oe), .i_raw_x(raw[0]),
        .i_raw_y(raw[1]), .i_raw_z(raw[2]), .i_stap_evt(ev[6]), .i_dtap_evt(ev[5]), .i_act_evt(ev[4]),
        .i_inact_evt(ev[3]), .i_ff_evt(ev[2]), .i_wm_evt(ev[1]), .i_ovr_evt(ev[0]), .o_irq_pin_a(o_irq_pin_a),
        .o_irq_pin_b(o_irq_pin_b), .o_low_power(o_low_power), .o_self_test(o_self_test),
        .o_measuring(o_measuring), .o_asleep(o_asleep), .o_rate_code(o_rate_code), .o_act_run(o_act_run),
        .o_inact_run(o_inact_run), .o_tap_ff_run(o_tap_ff_run), .o_sample(o_sample), .o_fifo_wr(o_fifo_wr));
    // Value compare; levels reuse it
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_v
    task automatic chk_b(input logic got, input logic exp);
        chk_v({15'h0000, got}, {15'h0000, exp});
    endtask : chk_b
    // Register write; model keeps only the writable bits
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_host.xfer({2'b00, a}, d, rv);
        if (a == spr_pkg::ADDR_RATE) mr[a] = d & spr_pkg::RATE_MASK;
        else if (a == spr_pkg::ADDR_PWR) mr[a] = d & spr_pkg::PWR_MASK;
        else if (a == spr_pkg::ADDR_FMT) mr[a] = d & spr_pkg::FMT_MASK;
        else if (a inside {spr_pkg::ADDR_EN, spr_pkg::ADDR_MAP}) mr[a] = d;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        u_host.xfer({2'b10, a}, 8'h00, rv);
    endtask : rd
    task automatic pulse(input int e);
        ev[e] = 1'b1;
        @(negedge i_core_clk);
        ev[e] = 1'b0;
        repeat (3) @(negedge i_core_clk);
    endtask : pulse
    task automatic pins();
        chk_b(o_irq_pin_a, (|(fl & mr[6'h2e] & ~mr[6'h2f])) ^ mr[6'h31][5]);
        chk_b(o_irq_pin_b, (|(fl & mr[6'h2e] & mr[6'h2f])) ^ mr[6'h31][5]);
    endtask : pins
    // Cycles between two samples, and store pulses within them
    task automatic gap(input int exp, input int fw);
        int c = 0;
        int nf = 0;
        while (o_sample !== 1'b1 && c < 20000) begin
            @(negedge i_core_clk);
            c++;
        end
        c = 0;
        do begin
            @(negedge i_core_clk);
            c++;
            nf += int'(o_fifo_wr);
        end while (o_sample !== 1'b1 && c < 20000);
        chk_v(16'(c), 16'(exp));
        chk_v(16'(nf), 16'(fw));
    endtask : gap
    // Expected output word from raw input and format byte
    function automatic logic [15:0] fmtv(input logic signed [15:0] r, input logic [7:0] f);
        int w = f[3] ? 10 + int'(f[1:0]) : 10;
        int v = f[3] ? int'(r) : int'(r >>> f[1:0]);
        int lim = (1 << (w - 1)) - 1;
        if (f[1:0] != 2'h3) v = v > lim ? lim : (v < -lim - 1 ? -lim - 1 : v);
        else v = (v <<< (32 - w)) >>> (32 - w);
        return f[2] ? 16'(v << (16 - w)) : 16'(v);
    endfunction : fmtv
    task automatic results();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    // Hang guard, well past the expected run
    initial begin
        #780_000;
        miscompares++;
        results();
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge i_core_clk);
        i_srst = 1'b0;
        repeat (4) @(negedge i_core_clk);
        chk_b(o_measuring, 1'b0);
        for (int i = 0; i < 5; i++) begin
            for (int a = 6'h2c; a <= 6'h31; a++) begin
                rd(6'(a));
                if (a != 6'h30) chk_v({8'h00, rv}, {8'h00, mr[a]});
                wr(6'(a), 8'($random(seed)));
            end
            wr(6'h3f, 8'hff);
            rd(6'h3f);
            chk_v({8'h00, rv}, 16'h0000);
            chk_v({o_low_power, o_rate_code}, 16'(mr[6'h2c][4:0]));
            chk_b(o_self_test, mr[6'h31][7]);
            chk_b(o_measuring, mr[6'h2d][3]);
        end
        wr(spr_pkg::ADDR_PWR, 8'h00);
        wr(spr_pkg::ADDR_MAP, 8'($random(seed)));
        wr(spr_pkg::ADDR_FMT, 8'($random(seed)) & 8'h6f);
        rd(spr_pkg::ADDR_SRC);
        rd(spr_pkg::ADDR_DX0);
        for (int e = 0; e < 7; e++) begin
            wr(spr_pkg::ADDR_EN, 8'($random(seed)) & 8'h7f);
            pulse(e);
            if (e < 2 || mr[6'h2e][e]) fl[e] = 1'b1;
            pins();
            rd(spr_pkg::ADDR_SRC);
            chk_v({8'h00, rv}, {8'h00, fl});
            fl = fl & ~spr_pkg::SRC_CLR_MASK;
            pins();
            rd(6'(spr_pkg::ADDR_DX0 + e % 6));
            fl = fl & ~spr_pkg::DATA_CLR_MASK;
            pins();
        end
        wr(spr_pkg::ADDR_PWR, 8'h08);
        for (int r = 10; r < 16; r++) begin
            wr(spr_pkg::ADDR_RATE, 8'(r));
            gap((1 << (15 - r)) * P_DIV, 1);
        end
        rd(spr_pkg::ADDR_SRC);
        chk_b(rv[7], 1'b1);
        for (int w = 0; w < 4; w++) begin
            wr(spr_pkg::ADDR_PWR, 8'(8'h0c | w));
            rd(spr_pkg::ADDR_DX0);
            gap((400 << w) * P_DIV, 0);
            rd(spr_pkg::ADDR_SRC);
            chk_b(rv[7], 1'b0);
        end
        wr(spr_pkg::ADDR_PWR, 8'h00);
        wr(spr_pkg::ADDR_PWR, 8'h08);
        for (int i = 0; i < 8; i++) begin
            wr(spr_pkg::ADDR_FMT, 8'($random(seed)) & 8'hcf);
            for (int k = 0; k < 3; k++) raw[k] = 16'($random(seed) >>> (i % 4) * 4);
            gap(P_DIV, 1);
            for (int k = 0; k < 3; k++) begin
                rd(6'(spr_pkg::ADDR_DX0 + 2 * k));
                lo = rv;
                rd(6'(spr_pkg::ADDR_DX1 + 2 * k));
                chk_v({rv, lo}, fmtv(raw[k], mr[6'h31]));
            end
        end
        wr(spr_pkg::ADDR_EN, 8'h18);
        wr(spr_pkg::ADDR_PWR, 8'h38);
        chk_v({o_act_run, o_inact_run}, 16'h0001);
        pulse(3);
        chk_v({o_asleep, o_act_run, o_inact_run, o_tap_ff_run}, 16'h000c);
        pulse(4);
        chk_b(o_asleep, 1'b0);
        gap(P_DIV, 1);
        wr(spr_pkg::ADDR_PWR, 8'h00);
        wr(spr_pkg::ADDR_PWR, 8'h18);
        pulse(3);
        chk_v({o_asleep, o_act_run, o_inact_run}, 16'h0003);
        results();
    end
endmodule : test_spr_regs

// File: verilog/spr_regs.sv
// Sensor-side power, interrupt and format registers behind a serial register port
// Overview of operation
// [RULE1] Rate bit D4 selects reduced-power operation
// [RULE2] Rate field sets output rate, reset 0x0A
// [RULE3] Link bit serialises activity and inactivity detection
// [RULE4] Linked auto-sleep sleeps on inactivity, wakes on activity
// [RULE5] Without link, never sleep automatically
// [RULE6] Measure bit selects measurement; power-up in standby
// [RULE7] Sleep hides data ready, stops FIFO, activity only
// [RULE8] Sleep still updates output data at sleep rate
// [RULE9] Sleep rate field gives 8, 4, 2, 1 Hz
// [RULE10] Host toggles standby before clearing sleep controls
// [RULE11] Shared event bit order; enable lets interrupt
// [RULE12] Ready, watermark, overrun functions always run
// [RULE13] Host configures functions before enabling interrupts
// [RULE14] Routing bit picks pin; pins OR events
// [RULE15] Data flags set always, cleared by data reads
// [RULE16] Reading source register clears other flags
// [RULE17] Format D7 applies self-test force
// [RULE18] Format D6 selects three-wire serial wiring
// [RULE19] Format D5 inverts interrupt pin polarity
// [RULE20] Constant-scale mode widens output with range
// [RULE21] Justify bit selects left or right alignment
// [RULE22] Range field selects 2, 4, 8, 16 g
// [RULE23] Saturate output except at the largest range
// [RULE24] Axis words little-endian from 0x32 upward
// [RULE25] Fixed-zero bits read zero, ignore writes
module spr_regs #(
    parameter int unsigned P_BASE_DIV = spr_pkg::BASE_DIV // Core cycles per base tick
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdio,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    output logic o_spi_sdio,
    output logic o_spi_sdio_oe,
    input wire logic signed [15:0] i_raw_x,
    input wire logic signed [15:0] i_raw_y,
    input wire logic signed [15:0] i_raw_z,
    input wire logic i_stap_evt,
    input wire logic i_dtap_evt,
    input wire logic i_act_evt,
    input wire logic i_inact_evt,
    input wire logic i_ff_evt,
    input wire logic i_wm_evt,
    input wire logic i_ovr_evt,
    output logic o_irq_pin_a,
    output logic o_irq_pin_b,
    output logic o_low_power,
    output logic o_self_test,
    output logic o_measuring,
    output logic o_asleep,
    output logic [3:0] o_rate_code,
    output logic o_act_run,
    output logic o_inact_run,
    output logic o_tap_ff_run,
    output logic o_sample,
    output logic o_fifo_wr
);
    // Whole state of the block
    typedef struct packed {
        logic [7:0] rate;
        logic [7:0] pwr;
        logic [7:0] int_en;
        logic [7:0] int_map;
        logic [7:0] flags;
        logic [7:0] fmt;
        logic [15:0] data_x;
        logic [15:0] data_y;
        logic [15:0] data_z;
        logic asleep;
        spr_pkg::spr_phase_t phase;
        logic [15:0] base_cnt;
        logic [15:0] rate_cnt;
        logic sclk_m;
        logic sclk_s;
        logic sclk_d;
        logic cs_m;
        logic cs_s;
        logic sdi_m;
        logic sdi_s;
        logic [2:0] bit_cnt;
        logic hdr_done;
        logic rw;
        logic mb;
        logic [5:0] addr;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic sdo;
        logic sdo_oe4;
        logic sdo_oe3;
        logic irq_a;
        logic irq_b;
        logic act_run;
        logic inact_run;
        logic tap_ff_run;
        logic sample;
        logic fifo_wr;
    } spr_state_t;

    spr_state_t s_r; // Registered state
    spr_state_t s_nxt; // Next state

    // Helpers shared with the checks below
    logic smp; // Output sample taken this cycle
    logic sleep_eff; // Manual or automatic sleep
    logic linked; // Link mode with both motion functions on
    logic act_ok; // Activity may be accepted
    logic inact_ok; // Inactivity may be accepted
    logic rd_src; // Host read of the source register
    logic rd_data; // Host read of an output data byte
    logic [7:0] ev_set; // Flags raised this cycle
    logic [7:0] clr; // Flags cleared by reads this cycle
    logic [15:0] fx; // Formatted axis words
    logic [15:0] fy;
    logic [15:0] fz;

    // Format one axis: scale, clip, align
    function automatic logic [15:0] fmt_axis(input logic signed [15:0] raw, input logic [7:0] f);
        logic [1:0] rng;
        logic [4:0] w;
        logic [4:0] sh;
        logic signed [15:0] v;
        logic signed [15:0] hi;
        logic signed [15:0] lo;
        logic signed [15:0] t;
        logic signed [15:0] l;
        rng = f[1:0]; // [RULE22]
        // Constant scale grows width; ten-bit mode shifts scale instead
        w = f[spr_pkg::FMT_FULL_BIT] ? spr_pkg::BASE_RES_W + {3'h0, rng} : spr_pkg::BASE_RES_W; // [RULE20]
        v = f[spr_pkg::FMT_FULL_BIT] ? raw : (raw >>> rng);
        hi = (16'sh0001 <<< (w - 5'h01)) - 16'sh0001;
        lo = -hi - 16'sh0001;
        t = v;
        // Clip to avoid rollover; the largest range wraps by design
        if (rng != spr_pkg::RANGE_MAX) begin // [RULE23]
            if (v > hi) begin
                t = hi;
            end else if (v < lo) begin
                t = lo;
            end
        end
        sh = spr_pkg::DATA_W - w;
        l = t <<< sh;
        // Left-justified keeps the shift, right-justified sign-extends back
        fmt_axis = f[spr_pkg::FMT_JUST_BIT] ? l : (l >>> sh); // [RULE21]
    endfunction : fmt_axis

    // All next-state logic
    always_comb begin
        logic rise;
        logic fall;
        logic [7:0] b;
        logic [5:0] rd_addr;
        logic do_rd;
        logic do_wr;
        logic [7:0] rd_byte;
        logic [15:0] period;
        logic tick;
        logic act_acc;
        logic inact_acc;
        rise = 1'b0;
        fall = 1'b0;
        b = 8'h00;
        rd_addr = 6'h00;
        do_rd = 1'b0;
        do_wr = 1'b0;
        rd_byte = 8'h00;
        period = 16'h0000;
        tick = 1'b0;
        act_acc = 1'b0;
        inact_acc = 1'b0;
        s_nxt = s_r;
        s_nxt.sample = 1'b0;
        s_nxt.fifo_wr = 1'b0;
        // Two-stage synchronisers on the link pins
        s_nxt.sclk_m = i_spi_sclk;
        s_nxt.sclk_s = s_r.sclk_m;
        s_nxt.sclk_d = s_r.sclk_s;
        s_nxt.cs_m = i_spi_cs_n;
        s_nxt.cs_s = s_r.cs_m;
        s_nxt.sdi_m = i_spi_sdio;
        s_nxt.sdi_s = s_r.sdi_m;
        rise = s_r.sclk_s & ~s_r.sclk_d;
        fall = ~s_r.sclk_s & s_r.sclk_d;

        // Serial slave: header byte then data bytes, clock idles high
        if (s_r.cs_s) begin
            s_nxt.bit_cnt = 3'h0;
            s_nxt.hdr_done = 1'b0;
            s_nxt.sdo_oe4 = 1'b0;
            s_nxt.sdo_oe3 = 1'b0;
        end else begin
            if (rise) begin
                b = {s_r.rx_sh[6:0], s_r.sdi_s};
                s_nxt.rx_sh = b;
                s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
                if (s_r.bit_cnt == 3'h7) begin
                    if (!s_r.hdr_done) begin
                        // Header: direction, burst, address
                        s_nxt.hdr_done = 1'b1;
                        s_nxt.rw = b[spr_pkg::HDR_RW_BIT];
                        s_nxt.mb = b[spr_pkg::HDR_MB_BIT];
                        s_nxt.addr = b[5:0];
                        rd_addr = b[5:0];
                        do_rd = b[spr_pkg::HDR_RW_BIT];
                    end else begin
                        do_wr = ~s_r.rw;
                        rd_addr = s_r.mb ? s_r.addr + 6'h01 : s_r.addr;
                        s_nxt.addr = rd_addr;
                        do_rd = s_r.rw;
                    end
                end
            end
            // Shift read data out on the falling edge; the selected wiring drives
            if (fall && s_r.hdr_done && s_r.rw) begin
                s_nxt.sdo = s_r.tx_sh[7];
                s_nxt.tx_sh = {s_r.tx_sh[6:0], 1'b0};
                s_nxt.sdo_oe3 = s_r.fmt[spr_pkg::FMT_SPI3_BIT]; // [RULE18]
                s_nxt.sdo_oe4 = ~s_r.fmt[spr_pkg::FMT_SPI3_BIT]; // [RULE18]
            end
        end

        // Register read mux; unmapped addresses read zero
        unique case (rd_addr)
            spr_pkg::ADDR_RATE: rd_byte = s_r.rate;
            spr_pkg::ADDR_PWR: rd_byte = s_r.pwr;
            spr_pkg::ADDR_EN: rd_byte = s_r.int_en;
            spr_pkg::ADDR_MAP: rd_byte = s_r.int_map;
            spr_pkg::ADDR_SRC: rd_byte = s_r.flags;
            spr_pkg::ADDR_FMT: rd_byte = s_r.fmt;
            spr_pkg::ADDR_DX0: rd_byte = s_r.data_x[7:0]; // [RULE24]
            spr_pkg::ADDR_DX1: rd_byte = s_r.data_x[15:8];
            spr_pkg::ADDR_DY0: rd_byte = s_r.data_y[7:0];
            spr_pkg::ADDR_DY1: rd_byte = s_r.data_y[15:8];
            spr_pkg::ADDR_DZ0: rd_byte = s_r.data_z[7:0];
            spr_pkg::ADDR_DZ1: rd_byte = s_r.data_z[15:8];
            default: rd_byte = 8'h00;
        endcase
        if (do_rd) begin
            s_nxt.tx_sh = rd_byte;
        end
        rd_src = do_rd && (rd_addr == spr_pkg::ADDR_SRC);
        rd_data = do_rd && (rd_addr >= spr_pkg::ADDR_DX0) && (rd_addr <= spr_pkg::ADDR_DZ1);

        // Register writes; fixed-zero bits masked, read-only addresses ignored
        if (do_wr) begin
            unique case (s_r.addr)
                spr_pkg::ADDR_RATE: s_nxt.rate = b & spr_pkg::RATE_MASK; // [RULE25]
                spr_pkg::ADDR_PWR: s_nxt.pwr = b & spr_pkg::PWR_MASK; // [RULE25]
                spr_pkg::ADDR_EN: s_nxt.int_en = b;
                spr_pkg::ADDR_MAP: s_nxt.int_map = b;
                spr_pkg::ADDR_FMT: s_nxt.fmt = b & spr_pkg::FMT_MASK; // [RULE25]
                default: s_nxt.addr = rd_addr; // Write dropped; burst address still advances
            endcase
        end

        // Sample timing from a base tick at the top output rate
        sleep_eff = s_r.pwr[spr_pkg::PWR_SLEEP_BIT] | s_r.asleep;
        tick = (s_r.base_cnt == 16'(P_BASE_DIV - 1));
        s_nxt.base_cnt = tick ? 16'h0000 : s_r.base_cnt + 16'h0001;
        period = sleep_eff ? (spr_pkg::SLEEP_BASE_TICKS << s_r.pwr[1:0]) // [RULE9]
                           : (16'h0001 << (spr_pkg::TOP_RATE_CODE - s_r.rate[3:0])); // [RULE2]
        smp = 1'b0;
        if (!s_r.pwr[spr_pkg::PWR_MEAS_BIT]) begin
            // Standby: no sampling
            s_nxt.rate_cnt = 16'h0000; // [RULE6]
        end else if (tick) begin
            if (s_r.rate_cnt >= period - 16'h0001) begin
                s_nxt.rate_cnt = 16'h0000;
                smp = 1'b1;
            end else begin
                s_nxt.rate_cnt = s_r.rate_cnt + 16'h0001;
            end
        end
        fx = fmt_axis(i_raw_x, s_r.fmt);
        fy = fmt_axis(i_raw_y, s_r.fmt);
        fz = fmt_axis(i_raw_z, s_r.fmt);
        // Output words update in sleep too; FIFO writes only when awake
        if (smp) begin
            s_nxt.data_x = fx; // [RULE8]
            s_nxt.data_y = fy;
            s_nxt.data_z = fz;
            s_nxt.sample = 1'b1;
            s_nxt.fifo_wr = ~sleep_eff; // [RULE7]
        end

        // Link mode gates which motion function may be accepted
        linked = s_r.pwr[spr_pkg::PWR_LINK_BIT] & s_r.int_en[spr_pkg::EV_ACT] & s_r.int_en[spr_pkg::EV_INACT];
        act_ok = ~linked | (s_r.phase == spr_pkg::spr_wait_act); // [RULE3]
        inact_ok = (~linked | (s_r.phase == spr_pkg::spr_wait_inact)) & ~sleep_eff; // [RULE3] [RULE7]
        act_acc = i_act_evt & s_r.int_en[spr_pkg::EV_ACT] & act_ok; // [RULE11]
        inact_acc = i_inact_evt & s_r.int_en[spr_pkg::EV_INACT] & inact_ok;
        if (linked && inact_acc) begin
            s_nxt.phase = spr_pkg::spr_wait_act; // [RULE3]
        end else if (linked && act_acc) begin
            s_nxt.phase = spr_pkg::spr_wait_inact;
        end else if (!linked) begin
            s_nxt.phase = spr_pkg::spr_wait_inact;
        end

        // Automatic sleep only under link with auto-sleep set
        if (!s_r.pwr[spr_pkg::PWR_LINK_BIT] || !s_r.pwr[spr_pkg::PWR_AUTO_BIT]) begin
            s_nxt.asleep = 1'b0; // [RULE5]
        end else if (inact_acc) begin
            s_nxt.asleep = 1'b1; // [RULE4]
        end else if (act_acc) begin
            s_nxt.asleep = 1'b0; // [RULE4]
        end

        // Event flags; in sleep only activity, watermark and overrun stay live
        ev_set = 8'h00;
        ev_set[spr_pkg::EV_DR] = smp & ~sleep_eff; // [RULE7] [RULE12] [RULE15]
        ev_set[spr_pkg::EV_STAP] = i_stap_evt & s_r.int_en[spr_pkg::EV_STAP] & ~sleep_eff; // [RULE11]
        ev_set[spr_pkg::EV_DTAP] = i_dtap_evt & s_r.int_en[spr_pkg::EV_DTAP] & ~sleep_eff;
        ev_set[spr_pkg::EV_ACT] = act_acc;
        ev_set[spr_pkg::EV_INACT] = inact_acc;
        ev_set[spr_pkg::EV_FF] = i_ff_evt & s_r.int_en[spr_pkg::EV_FF] & ~sleep_eff;
        ev_set[spr_pkg::EV_WM] = i_wm_evt; // [RULE12] [RULE15]
        ev_set[spr_pkg::EV_OVR] = i_ovr_evt; // [RULE12] [RULE15]
        clr = (rd_src ? spr_pkg::SRC_CLR_MASK : 8'h00) // [RULE16]
            | (rd_data ? spr_pkg::DATA_CLR_MASK : 8'h00); // [RULE15]
        // A new event beats a clearing read in the same cycle
        s_nxt.flags = (s_r.flags & ~clr) | ev_set;

        // Pins OR their routed enabled flags, then apply polarity
        s_nxt.irq_a = (|(s_nxt.flags & s_r.int_en & ~s_r.int_map)) ^ s_r.fmt[spr_pkg::FMT_INV_BIT]; // [RULE14] [RULE19]
        s_nxt.irq_b = (|(s_nxt.flags & s_r.int_en & s_r.int_map)) ^ s_r.fmt[spr_pkg::FMT_INV_BIT]; // [RULE14] [RULE19]

        // Run enables towards the detectors
        s_nxt.act_run = s_r.pwr[spr_pkg::PWR_MEAS_BIT] & s_r.int_en[spr_pkg::EV_ACT] & act_ok;
        s_nxt.inact_run = s_r.pwr[spr_pkg::PWR_MEAS_BIT] & s_r.int_en[spr_pkg::EV_INACT] & inact_ok;
        s_nxt.tap_ff_run = s_r.pwr[spr_pkg::PWR_MEAS_BIT] & ~sleep_eff; // [RULE7]

        // Synchronous reset; link pins idle high so no false edge follows
        if (i_srst) begin
            s_nxt = '0;
            s_nxt.rate = spr_pkg::RATE_RST; // [RULE2]
            s_nxt.sclk_m = 1'b1;
            s_nxt.sclk_s = 1'b1;
            s_nxt.sclk_d = 1'b1;
            s_nxt.cs_m = 1'b1;
            s_nxt.cs_s = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        s_r <= s_nxt;
    end

    // Outputs straight from state bits
    assign o_spi_sdo = s_r.sdo;
    assign o_spi_sdo_oe = s_r.sdo_oe4;
    assign o_spi_sdio = s_r.sdo;
    assign o_spi_sdio_oe = s_r.sdo_oe3;
    assign o_irq_pin_a = s_r.irq_a;
    assign o_irq_pin_b = s_r.irq_b;
    assign o_low_power = s_r.rate[spr_pkg::RATE_LP_BIT]; // [RULE1]
    assign o_self_test = s_r.fmt[spr_pkg::FMT_ST_BIT]; // [RULE17]
    assign o_measuring = s_r.pwr[spr_pkg::PWR_MEAS_BIT]; // [RULE6]
    assign o_asleep = s_r.asleep;
    assign o_rate_code = s_r.rate[3:0];
    assign o_act_run = s_r.act_run;
    assign o_inact_run = s_r.inact_run;
    assign o_tap_ff_run = s_r.tap_ff_run;
    assign o_sample = s_r.sample;
    assign o_fifo_wr = s_r.fifo_wr;

    // Checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    sequence src_read_s;
        rd_src && ((ev_set & spr_pkg::SRC_CLR_MASK) == 8'h00);
    endsequence
    sequence sleep_sample_s;
        smp && sleep_eff;
    endsequence

    standby_reset_a: assert property ($past(i_srst) |-> !o_measuring) // [RULE6]
        else $error("not in standby after reset");
    src_clear_a: assert property (src_read_s |=> ((s_r.flags & spr_pkg::SRC_CLR_MASK) == 8'h00)) // [RULE16]
        else $error("source read left motion flags set");
    sleep_no_dr_a: assert property (sleep_sample_s and !s_r.flags[spr_pkg::EV_DR] |=> !s_r.flags[spr_pkg::EV_DR]) // [RULE7]
        else $error("data ready raised in sleep");
    sleep_update_a: assert property (sleep_sample_s |=> (s_r.data_x == $past(fx)) && (s_r.data_z == $past(fz))) // [RULE8]
        else $error("output data not updated in sleep");
    dr_set_a: assert property (smp && !sleep_eff |=> s_r.flags[spr_pkg::EV_DR] ##1 (o_sample == 1'b0)) // [RULE15]
        else $error("data ready flag not set on sample");
    no_auto_sleep_a: assert property (!s_r.pwr[spr_pkg::PWR_LINK_BIT] [*2] |-> !o_asleep) // [RULE5]
        else $error("auto sleep without link");
    auto_enter_a: assert property (s_r.pwr[spr_pkg::PWR_LINK_BIT] && s_r.pwr[spr_pkg::PWR_AUTO_BIT]
        && ev_set[spr_pkg::EV_INACT] |=> o_asleep ##1 !o_fifo_wr) // [RULE4]
        else $error("no sleep after linked inactivity");
    pin_route_a: assert property (((s_nxt.flags & s_r.int_en & s_r.int_map) == 8'h00)
        && !s_r.fmt[spr_pkg::FMT_INV_BIT] |=> !o_irq_pin_b) // [RULE14]
        else $error("second pin raised without routed event");
    polarity_a: assert property (s_r.fmt[spr_pkg::FMT_INV_BIT] && ((s_nxt.flags & s_r.int_en) == 8'h00)
        |=> o_irq_pin_a && o_irq_pin_b) // [RULE19]
        else $error("inverted pins not idle high");
endmodule : spr_regs
